// file: rtl/pin_override_slice.sv
// Override merge for one port: chooses override or normal control per pin.
// Assumes all inputs are synchronous to the caller's clock; purely combinational.
`default_nettype none

module pin_override_slice #(
	parameter int W = 8
) (
	// Normal port control
	input wire logic [W-1:0] i_norm_pullup,
	input wire logic [W-1:0] i_norm_dir,
	input wire logic [W-1:0] i_norm_out,
	input wire logic [W-1:0] i_norm_gate,
	// Override controls
	input wire logic [W-1:0] i_pullup_override_enable,
	input wire logic [W-1:0] i_pullup_override_value,
	input wire logic [W-1:0] i_direction_override_enable,
	input wire logic [W-1:0] i_direction_override_value,
	input wire logic [W-1:0] i_output_override_enable,
	input wire logic [W-1:0] i_output_override_value,
	input wire logic [W-1:0] i_input_gate_override_enable,
	input wire logic [W-1:0] i_input_gate_override_value,
	// Pin level
	input wire logic [W-1:0] i_pin,
	// Pad controls and gated input
	output logic [W-1:0] o_pullup,
	output logic [W-1:0] o_dir,
	output logic [W-1:0] o_out,
	output logic [W-1:0] o_gate,
	output logic [W-1:0] o_in
);
	// ==========================================================
	// Per-pin selection
	assign o_pullup = (i_pullup_override_enable & i_pullup_override_value)
		| (~i_pullup_override_enable & i_norm_pullup);
	assign o_dir = (i_direction_override_enable & i_direction_override_value)
		| (~i_direction_override_enable & i_norm_dir);
	assign o_out = (i_output_override_enable & i_output_override_value)
		| (~i_output_override_enable & i_norm_out);
	assign o_gate = (i_input_gate_override_enable & i_input_gate_override_value)
		| (~i_input_gate_override_enable & i_norm_gate);
	assign o_in = i_pin & o_gate;
endmodule

`default_nettype wire

// file: rtl/port_d_e_alternate_function_mux.sv
// Alternate-function pin mux for Port D (segment driver, irq0, capture) and Port E.
// Assumes normal port control comes from the port registers and peripherals sit on i_mclk.
`default_nettype none

module port_d_e_alternate_function_mux #(
	parameter int PORT_W = port_mux_pkg::PORT_W,
	parameter int MASK_W = port_mux_pkg::MASK_W
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Segment driver and irq0 control
	input wire logic i_segment_driver_enable,
	input wire logic [MASK_W-1:0] i_segment_port_mask,
	input wire logic i_ext_irq_zero_enable,
	// Port D normal control and pins
	input wire logic [PORT_W-1:0] i_pd_latch,
	input wire logic [PORT_W-1:0] i_pd_dir,
	input wire logic [PORT_W-1:0] i_pd_pullup,
	input wire logic [PORT_W-1:0] i_pd_gate,
	input wire logic [PORT_W-1:0] i_pd_pin,
	// Port E normal control and pins
	input wire logic [PORT_W-1:0] i_pe_latch,
	input wire logic [PORT_W-1:0] i_pe_dir,
	input wire logic [PORT_W-1:0] i_pe_pullup,
	input wire logic [PORT_W-1:0] i_pe_gate,
	input wire logic [PORT_W-1:0] i_pe_pin,
	// Clock output
	input wire logic i_clock_out_fuse,
	input wire logic i_divided_clock,
	// Usart
	input wire logic i_usart_sync_mode,
	input wire logic i_usart_clock_out,
	input wire logic i_usart_tx_enable,
	input wire logic i_usart_tx_out,
	// Universal serial unit and two-wire unit
	input wire logic i_serial_three_wire,
	input wire logic i_serial_data_out,
	input wire logic i_two_wire_mode,
	input wire logic i_sda_release,
	input wire logic i_scl_hold,
	// Comparator digital input disables
	input wire logic i_comp_pos_digital_off,
	input wire logic i_comp_neg_digital_off,
	// Pin-change enables
	input wire logic i_pin_change_enable,
	input wire logic [PORT_W-1:0] i_pin_change_mask,
	// Port D pad controls
	output logic [PORT_W-1:0] o_pd_pullup,
	output logic [PORT_W-1:0] o_pd_dir,
	output logic [PORT_W-1:0] o_pd_out,
	output logic [PORT_W-1:0] o_pd_gate,
	output logic [PORT_W-1:0] o_pd_segment_sel,
	// Port E pad controls
	output logic [PORT_W-1:0] o_pe_pullup,
	output logic [PORT_W-1:0] o_pe_dir,
	output logic [PORT_W-1:0] o_pe_out,
	output logic [PORT_W-1:0] o_pe_gate,
	// Peripheral inputs
	output logic o_ext_irq_zero_input,
	output logic o_capture_trigger_input,
	output logic [PORT_W-1:0] o_pin_change_source,
	output logic o_serial_unit_data_in,
	output logic o_serial_unit_clock,
	output logic o_usart_ext_clock,
	// Comparator paths
	output logic o_comparator_pos_input,
	output logic o_comparator_neg_input
);
	// ==========================================================
	// Segment takeover decode
	function automatic logic seg_take(input logic en, input logic [MASK_W-1:0] mask,
		input logic [MASK_W-1:0] thr);
		seg_take = en & (mask > thr);
	endfunction

	wire logic seg_d76 = seg_take(i_segment_driver_enable, i_segment_port_mask,
		port_mux_pkg::SEG_THR_D76);
	wire logic seg_d54 = seg_take(i_segment_driver_enable, i_segment_port_mask,
		port_mux_pkg::SEG_THR_D54);
	wire logic seg_d32 = seg_take(i_segment_driver_enable, i_segment_port_mask,
		port_mux_pkg::SEG_THR_D32);
	wire logic seg_d10 = seg_take(i_segment_driver_enable, i_segment_port_mask,
		port_mux_pkg::SEG_THR_D10);

	wire logic [PORT_W-1:0] pd_seg = {seg_d76, seg_d76, seg_d54, seg_d54,
		seg_d32, seg_d32, seg_d10, seg_d10};

	// ==========================================================
	// Port D overrides
	wire logic pd1_gate_oe = i_segment_driver_enable | i_ext_irq_zero_enable;
	wire logic pd1_gate_ov = i_segment_driver_enable & i_ext_irq_zero_enable;

	wire logic [PORT_W-1:0] pd_gate_oe = {pd_seg[7:2], pd1_gate_oe, pd_seg[0]};
	wire logic [PORT_W-1:0] pd_gate_ov = {6'h00, pd1_gate_ov, 1'h0};
	wire logic [PORT_W-1:0] pd_zero = '0;

	// Segment lines 15..22 reach the pads through the analog path
	assign o_pd_segment_sel = pd_seg;

	// Gated Port D pins feed irq0 and capture
	wire logic [PORT_W-1:0] pd_in;

	pin_override_slice #(
		.W(PORT_W)
	) u_pd (
		.i_norm_pullup(i_pd_pullup),
		.i_norm_dir(i_pd_dir),
		.i_norm_out(i_pd_latch),
		.i_norm_gate(i_pd_gate),
		.i_pullup_override_enable(pd_seg),
		.i_pullup_override_value(pd_zero),
		.i_direction_override_enable(pd_seg),
		.i_direction_override_value(pd_zero),
		.i_output_override_enable(pd_zero),
		.i_output_override_value(pd_zero),
		.i_input_gate_override_enable(pd_gate_oe),
		.i_input_gate_override_value(pd_gate_ov),
		.i_pin(i_pd_pin),
		.o_pullup(o_pd_pullup),
		.o_dir(o_pd_dir),
		.o_out(o_pd_out),
		.o_gate(o_pd_gate),
		.o_in(pd_in)
	);

	// ==========================================================
	// Port E override terms
	wire logic [PORT_W-1:0] pc_on = i_pin_change_mask & {PORT_W{i_pin_change_enable}};

	// Clock out ignores latch and direction, and reset does not stop it
	wire logic e7_clk_on = i_clock_out_fuse;

	// Usart clock is an output only in synchronous mode with direction set
	wire logic e2_clk_drive = i_usart_sync_mode
		& i_pe_dir[port_mux_pkg::PIN_USART_CK];

	// Two-wire lines are open drain: only the direction is switched
	wire logic e5_dir = ~(i_sda_release & i_pe_latch[port_mux_pkg::PIN_SER_DI])
		& i_pe_dir[port_mux_pkg::PIN_SER_DI];
	wire logic e4_dir = ~(~i_scl_hold & i_pe_latch[port_mux_pkg::PIN_SER_CK])
		& i_pe_dir[port_mux_pkg::PIN_SER_CK];

	// Pull-up off on the two-wire data line and on the transmit pin
	wire logic [PORT_W-1:0] pe_pu_oe = {2'h0, i_two_wire_mode, 3'h0,
		i_usart_tx_enable, 1'h0};
	wire logic [PORT_W-1:0] pe_dir_oe = {e7_clk_on, 1'h0, i_two_wire_mode, i_two_wire_mode,
		2'h0, i_usart_tx_enable, 1'h0};
	wire logic [PORT_W-1:0] pe_dir_ov = {1'h1, 1'h0, e5_dir, e4_dir, 2'h0, 1'h1, 1'h0};
	// Output drivers override the latch only where a unit owns the pin
	wire logic [PORT_W-1:0] pe_out_oe = {e7_clk_on, i_serial_three_wire,
		i_two_wire_mode & i_pe_dir[port_mux_pkg::PIN_SER_DI],
		i_two_wire_mode & i_pe_dir[port_mux_pkg::PIN_SER_CK],
		1'h0, e2_clk_drive, i_usart_tx_enable, 1'h0};
	wire logic [PORT_W-1:0] pe_out_ov = {i_divided_clock, i_serial_data_out, 2'h0,
		1'h0, i_usart_clock_out, i_usart_tx_out, 1'h0};

	// Pin-change sources force the input gate open; comparator disables close it on pins that are not pin-change sources
	wire logic e3_off = i_comp_neg_digital_off & ~pc_on[port_mux_pkg::PIN_COMP_NEG];
	wire logic e2_off = i_comp_pos_digital_off & ~pc_on[port_mux_pkg::PIN_USART_CK];
	wire logic [PORT_W-1:0] pe_gate_oe = pc_on | {4'h0, i_comp_neg_digital_off,
		i_comp_pos_digital_off, 2'h0};
	wire logic [PORT_W-1:0] pe_gate_ov = ~{4'h0, e3_off, e2_off, 2'h0};
	wire logic [PORT_W-1:0] pe_zero = '0;

	// Gated Port E pins feed pin-change, serial and usart inputs
	wire logic [PORT_W-1:0] pe_in;

	pin_override_slice #(
		.W(PORT_W)
	) u_pe (
		.i_norm_pullup(i_pe_pullup),
		.i_norm_dir(i_pe_dir),
		.i_norm_out(i_pe_latch),
		.i_norm_gate(i_pe_gate),
		.i_pullup_override_enable(pe_pu_oe),
		.i_pullup_override_value(pe_zero),
		.i_direction_override_enable(pe_dir_oe),
		.i_direction_override_value(pe_dir_ov),
		.i_output_override_enable(pe_out_oe),
		.i_output_override_value(pe_out_ov),
		.i_input_gate_override_enable(pe_gate_oe),
		.i_input_gate_override_value(pe_gate_ov),
		.i_pin(i_pe_pin),
		.o_pullup(o_pe_pullup),
		.o_dir(o_pe_dir),
		.o_out(o_pe_out),
		.o_gate(o_pe_gate),
		.o_in(pe_in)
	);

	// ==========================================================
	// Comparator inputs are direct pad connections
	assign o_comparator_neg_input = i_pe_pin[port_mux_pkg::PIN_COMP_NEG];
	assign o_comparator_pos_input = i_pe_pin[port_mux_pkg::PIN_USART_CK];

	// ==========================================================
	// Registered peripheral inputs
	wire logic usart_ck_next = i_usart_sync_mode & ~i_pe_dir[port_mux_pkg::PIN_USART_CK]
		& pe_in[port_mux_pkg::PIN_USART_CK];

	// One register stage keeps peripheral inputs free of pad glitches
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ext_irq_zero_input <= port_mux_pkg::RST_BIT;
			o_capture_trigger_input <= port_mux_pkg::RST_BIT;
			o_pin_change_source <= port_mux_pkg::RST_BYTE;
			o_serial_unit_data_in <= port_mux_pkg::RST_BIT;
			o_serial_unit_clock <= port_mux_pkg::RST_BIT;
			o_usart_ext_clock <= port_mux_pkg::RST_BIT;
		end else begin
			o_ext_irq_zero_input <= pd_in[port_mux_pkg::PIN_IRQ0];
			o_capture_trigger_input <= pd_in[port_mux_pkg::PIN_CAPTURE];
			o_pin_change_source <= pe_in;
			o_serial_unit_data_in <= pe_in[port_mux_pkg::PIN_SER_DI];
			o_serial_unit_clock <= pe_in[port_mux_pkg::PIN_SER_CK];
			o_usart_ext_clock <= usart_ck_next;
		end
	end
endmodule

`default_nettype wire

// file: rtl/port_mux_pkg.sv
// Constants shared by the Port D / Port E alternate-function pin mux.
// Assumes the surrounding port logic supplies per-pin latch, direction and pull-up values.
`default_nettype none

package port_mux_pkg;
	// ==========================================================
	// Widths
	localparam int PORT_W = 8;
	localparam int MASK_W = 3;

	// ==========================================================
	// Segment port mask thresholds
	localparam logic [MASK_W-1:0] SEG_THR_D76 = 3'h1;
	localparam logic [MASK_W-1:0] SEG_THR_D54 = 3'h2;
	localparam logic [MASK_W-1:0] SEG_THR_D32 = 3'h3;
	localparam logic [MASK_W-1:0] SEG_THR_D10 = 3'h4;

	// ==========================================================
	// Pin positions
	localparam int PIN_IRQ0 = 1;
	localparam int PIN_CAPTURE = 0;
	localparam int PIN_CLKOUT = 7;
	localparam int PIN_SER_DO = 6;
	localparam int PIN_SER_DI = 5;
	localparam int PIN_SER_CK = 4;
	localparam int PIN_COMP_NEG = 3;
	localparam int PIN_USART_CK = 2;
	localparam int PIN_USART_TX = 1;

	// ==========================================================
	// Reset values of registered peripheral inputs
	localparam logic RST_BIT = 1'h0;
	localparam logic [PORT_W-1:0] RST_BYTE = 8'h00;
endpackage

`default_nettype wire

// file: sim/mux_chk.sv
// Checker for the Port D / Port E alternate-function mux, bound to its top module.
// Assumes one clock domain and that inputs change away from the rising edge.
`default_nettype none

module mux_chk #(
	parameter int PORT_W = 8,
	parameter int MASK_W = 3
) (
	// Clock, reset and controls
	input wire logic i_mclk, i_rst_b, i_segment_driver_enable, i_ext_irq_zero_enable,
	input wire logic [MASK_W-1:0] i_segment_port_mask,
	input wire logic i_clock_out_fuse, i_divided_clock, i_usart_sync_mode, i_usart_clock_out,
	input wire logic i_usart_tx_enable, i_usart_tx_out, i_serial_three_wire, i_serial_data_out,
	input wire logic i_comp_pos_digital_off, i_comp_neg_digital_off, i_pin_change_enable,
	input wire logic i_two_wire_mode,
	input wire logic [PORT_W-1:0] i_pd_dir, i_pd_pullup, i_pd_gate, i_pd_pin,
	input wire logic [PORT_W-1:0] i_pe_dir, i_pe_gate, i_pe_pin, i_pin_change_mask,
	// Watched outputs
	input wire logic [PORT_W-1:0] o_pd_pullup, o_pd_dir, o_pd_gate,
	input wire logic [PORT_W-1:0] o_pe_pullup, o_pe_dir, o_pe_out, o_pin_change_source,
	input wire logic o_ext_irq_zero_input, o_capture_trigger_input, o_usart_ext_clock,
	input wire logic o_comparator_pos_input, o_comparator_neg_input
);
	// ==========================================================
	// Expected override terms
	wire logic seg = i_segment_driver_enable;
	wire logic [7:0] d_ov = {8{seg}} & {{2{i_segment_port_mask > 3'h1}},
		{2{i_segment_port_mask > 3'h2}}, {2{i_segment_port_mask > 3'h3}},
		{2{i_segment_port_mask > 3'h4}}};
	wire logic [7:0] g_oe = {d_ov[7:2], seg | i_ext_irq_zero_enable, d_ov[0]};
	wire logic [7:0] d_gate = (g_oe & {6'h00, seg & i_ext_irq_zero_enable, 1'h0}) |
		(~g_oe & i_pd_gate);
	wire logic [7:0] d_in = i_pd_pin & d_gate;
	wire logic [7:0] pc_exp = i_pe_pin & (i_pin_change_mask | i_pe_gate);

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	// ==========================================================
	// Assertions
	sequence pc_plain;
		i_pin_change_enable && !i_comp_pos_digital_off && !i_comp_neg_digital_off;
	endsequence
	sequence xck_driving;
		i_usart_sync_mode && i_pe_dir[2];
	endsequence

	AST_D_HIGH: assert property (o_pd_dir[7:4] == (~d_ov[7:4] & i_pd_dir[7:4]) &&
		o_pd_pullup[7:4] == (~d_ov[7:4] & i_pd_pullup[7:4]))
		else $error("port D upper pad controls wrong");
	AST_D_LOW: assert property (o_pd_dir[3:0] == (~d_ov[3:0] & i_pd_dir[3:0]) &&
		o_pd_pullup[3:0] == (~d_ov[3:0] & i_pd_pullup[3:0]))
		else $error("port D lower pad controls wrong");
	AST_D_GATE: assert property (o_pd_gate == d_gate)
		else $error("port D input gates wrong");
	AST_IRQ0: assert property (1'h1 |=> o_ext_irq_zero_input == $past(d_in[1]))
		else $error("irq0 input does not follow gated D1");
	AST_CAPT: assert property (1'h1 |=> o_capture_trigger_input == $past(d_in[0]))
		else $error("capture input does not follow gated D0");
	AST_DIVIDED_CLOCK_OUT: assert property (disable iff (1'h0) i_clock_out_fuse |->
		o_pe_dir[7] && o_pe_out[7] == i_divided_clock)
		else $error("divided clock missing on E7");
	AST_XCK_OUT: assert property (xck_driving |-> o_pe_out[2] == i_usart_clock_out)
		else $error("usart clock not driven on E2");
	AST_XCK_OFF: assert property (!i_usart_sync_mode |=> !o_usart_ext_clock)
		else $error("usart clock input active outside sync mode");
	AST_PCINT: assert property (pc_plain |=> o_pin_change_source == $past(pc_exp))
		else $error("pin change source wrong");
	AST_COMP: assert property (o_comparator_neg_input == i_pe_pin[3] &&
		o_comparator_pos_input == i_pe_pin[2])
		else $error("comparator path wrong");
	AST_DO: assert property (i_serial_three_wire |-> o_pe_out[6] == i_serial_data_out)
		else $error("serial data out missing on E6");
	AST_TXD: assert property (i_usart_tx_enable |-> o_pe_dir[1] && !o_pe_pullup[1] &&
		o_pe_out[1] == i_usart_tx_out)
		else $error("usart transmit missing on E1");
	AST_TWI_PU: assert property (i_two_wire_mode |-> !o_pe_pullup[5])
		else $error("pull-up left on two-wire data line");
endmodule

bind port_d_e_alternate_function_mux mux_chk #(.PORT_W(PORT_W), .MASK_W(MASK_W)) u_mux_chk (.*);

`default_nettype wire

// file: sim/pad_model.sv
// Far-side pad model: resolves each pin from the mux's pad controls and the outside world.
// Assumes a pin the mux drives shows its output value, else the outside drive.
`default_nettype none

module pad_model (
	// Pad controls from the mux
	input wire logic [7:0] i_dir,
	input wire logic [7:0] i_out,
	// Level driven by the outside world
	input wire logic [7:0] i_ext,
	// Resolved pin level
	output logic [7:0] o_pin
);
	assign o_pin = (i_dir & i_out) | (~i_dir & i_ext);
endmodule

`default_nettype wire

// file: sim/test_port_d_e_alternate_function_mux.sv
// Self-checking bench for the Port D / Port E alternate-function mux.
// Assumes the pad model stands for the Port E pins; Port D pins are driven directly.
`default_nettype none

module test_port_d_e_alternate_function_mux;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk, i_rst_b, i_segment_driver_enable, i_ext_irq_zero_enable, i_clock_out_fuse;
	logic i_divided_clock, i_usart_sync_mode, i_usart_clock_out, i_usart_tx_enable;
	logic i_usart_tx_out, i_serial_three_wire, i_serial_data_out, i_two_wire_mode;
	logic i_sda_release, i_scl_hold, i_comp_pos_digital_off, i_comp_neg_digital_off;
	logic i_pin_change_enable;
	logic [2:0] i_segment_port_mask;
	logic [7:0] i_pd_latch, i_pd_dir, i_pd_pullup, i_pd_gate, i_pd_pin, i_pe_latch, i_pe_dir;
	logic [7:0] i_pe_pullup, i_pe_gate, i_pin_change_mask, pe_ext, i_pe_pin, ov;
	logic [7:0] o_pd_pullup, o_pd_dir, o_pd_out, o_pd_gate, o_pd_segment_sel, o_pe_pullup;
	logic [7:0] o_pe_dir, o_pe_out, o_pe_gate, o_pin_change_source;
	logic o_ext_irq_zero_input, o_capture_trigger_input, o_serial_unit_data_in;
	logic o_serial_unit_clock, o_usart_ext_clock, o_comparator_pos_input, o_comparator_neg_input;
	int miscompares = 0;
	int tests_run = 0;

	port_d_e_alternate_function_mux u_port_d_e_alternate_function_mux (.*);
	pad_model u_pad_model (.i_dir(o_pe_dir), .i_out(o_pe_out), .i_ext(pe_ext), .o_pin(i_pe_pin));

	always #25 i_mclk = ~i_mclk;

	// ==========================================================
	// Tasks
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#5;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		{i_mclk, i_rst_b, i_segment_driver_enable, i_ext_irq_zero_enable, i_clock_out_fuse} = 5'h00;
		{i_divided_clock, i_usart_sync_mode, i_usart_clock_out, i_usart_tx_enable} = 4'h0;
		{i_usart_tx_out, i_serial_three_wire, i_serial_data_out, i_two_wire_mode} = 4'h0;
		{i_sda_release, i_scl_hold, i_comp_pos_digital_off, i_comp_neg_digital_off} = 4'h0;
		{i_pin_change_enable, i_segment_port_mask} = 4'h0;
		{i_pd_latch, i_pd_dir, i_pd_pullup, i_pd_gate, i_pd_pin} = {5{8'hFF}};
		{i_pe_latch, i_pe_dir, i_pe_pullup, i_pin_change_mask} = {4{8'h00}};
		i_pe_gate = 8'hFF;
		pe_ext = 8'hA5;
		tick(4);
		i_rst_b = 1'h1;
		i_segment_driver_enable = 1'h1;
		for (int m = 0; m < 8; m++) begin
			i_segment_port_mask = m[2:0];
			ov = {{2{i_segment_port_mask > 3'h1}}, {2{i_segment_port_mask > 3'h2}},
				{2{i_segment_port_mask > 3'h3}}, {2{i_segment_port_mask > 3'h4}}};
			#1;
			chk(o_pd_dir, ~ov);
			chk(o_pd_pullup, ~ov);
			chk(o_pd_gate, ~ov & 8'hFD);
			chk(o_pd_segment_sel, ov);
			chk(o_pd_out, 8'hFF);
			tick(1);
		end
		i_segment_driver_enable = 1'h0;
		i_pd_dir = 8'h5A;
		#1;
		chk(o_pd_dir, 8'h5A);
		i_ext_irq_zero_enable = 1'h1;
		i_pd_pin = 8'h03;
		tick(1);
		chk({7'h00, o_ext_irq_zero_input}, 8'h00);
		i_segment_driver_enable = 1'h1;
		i_segment_port_mask = 3'h0;
		tick(1);
		chk({7'h00, o_ext_irq_zero_input}, 8'h01);
		chk({7'h00, o_capture_trigger_input}, 8'h01);
		i_segment_port_mask = 3'h5;
		tick(1);
		chk({6'h00, o_ext_irq_zero_input, o_capture_trigger_input}, 8'h02);
		i_clock_out_fuse = 1'h1;
		i_rst_b = 1'h0;
		i_divided_clock = 1'h1;
		#1;
		chk({6'h00, o_pe_dir[7], o_pe_out[7]}, 8'h03);
		i_divided_clock = 1'h0;
		#1;
		chk({6'h00, o_pe_dir[7], o_pe_out[7]}, 8'h02);
		tick(1);
		i_rst_b = 1'h1;
		i_divided_clock = 1'h1;
		#1;
		chk({6'h00, o_pe_dir[7], o_pe_out[7]}, 8'h03);
		i_clock_out_fuse = 1'h0;
		#1;
		chk({6'h00, o_pe_dir[7], o_pe_out[7]}, 8'h00);
		i_usart_sync_mode = 1'h1;
		i_pe_dir = 8'h04;
		i_usart_clock_out = 1'h1;
		#1;
		chk({7'h00, o_pe_out[2]}, 8'h01);
		i_usart_sync_mode = 1'h0;
		#1;
		chk({7'h00, o_pe_out[2]}, 8'h00);
		i_usart_sync_mode = 1'h1;
		i_pe_dir = 8'h00;
		tick(1);
		chk({7'h00, o_usart_ext_clock}, 8'h01);
		i_usart_sync_mode = 1'h0;
		tick(1);
		chk({7'h00, o_usart_ext_clock}, 8'h00);
		i_pe_gate = 8'h00;
		i_pin_change_enable = 1'h1;
		i_pin_change_mask = 8'hFF;
		tick(1);
		chk(o_pin_change_source, 8'hA5);
		chk({6'h00, o_comparator_neg_input, o_comparator_pos_input}, 8'h01);
		pe_ext = 8'h5A;
		tick(1);
		chk(o_pin_change_source, 8'h5A);
		chk({6'h00, o_comparator_neg_input, o_comparator_pos_input}, 8'h02);
		i_pin_change_mask = 8'h0F;
		tick(1);
		chk(o_pin_change_source, 8'h0A);
		chk(o_pe_gate, 8'h0F);
		i_pin_change_mask = 8'hF0;
		{i_comp_pos_digital_off, i_comp_neg_digital_off} = 2'h3;
		#1;
		chk(o_pe_gate, 8'hF0);
		chk({6'h00, o_comparator_neg_input, o_comparator_pos_input}, 8'h02);
		i_pin_change_mask = 8'hFF;
		#1;
		chk(o_pe_gate, 8'hFF);
		{i_comp_pos_digital_off, i_comp_neg_digital_off} = 2'h0;
		i_serial_three_wire = 1'h1;
		i_serial_data_out = 1'h1;
		i_pe_pullup = 8'hFF;
		i_usart_tx_enable = 1'h1;
		i_usart_tx_out = 1'h1;
		#1;
		chk({7'h00, o_pe_out[6]}, 8'h01);
		chk({5'h00, o_pe_pullup[1], o_pe_dir[1], o_pe_out[1]}, 8'h03);
		i_usart_tx_out = 1'h0;
		#1;
		chk({5'h00, o_pe_pullup[1], o_pe_dir[1], o_pe_out[1]}, 8'h02);
		i_two_wire_mode = 1'h1;
		i_sda_release = 1'h1;
		i_scl_hold = 1'h1;
		{i_pe_dir, i_pe_latch, i_pe_gate, pe_ext} = {8'h30, 8'h30, 8'hFF, 8'h30};
		tick(1);
		chk(o_pe_pullup, 8'hDD);
		chk(o_pe_dir, 8'h12);
		chk(o_pe_out, 8'h40);
		chk({6'h00, o_serial_unit_data_in, o_serial_unit_clock}, 8'h02);
		i_scl_hold = 1'h0;
		tick(1);
		chk({6'h00, o_serial_unit_data_in, o_serial_unit_clock}, 8'h03);
		chk(o_pe_dir, 8'h02);
		tick(2);
		print_verdict;
	end

	initial begin
		#100000;
		miscompares++;
		print_verdict;
	end
endmodule

`default_nettype wire
